/* File: shared/sadc_pkg.sv */
package sadc_pkg;

    // ==========================================================
    // frame layout
    // ==========================================================
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned RESULT_BITS  = 12;
    localparam int unsigned LEAD_ZEROS   = 4;
    localparam logic [4:0]  CNT_TRACK    = 5'h0E; // 14th falling edge
    localparam logic [4:0]  CNT_LAST     = 5'h0F; // 15th falling edge
    localparam logic [4:0]  CNT_FULL     = 5'h10; // 16th falling edge
    localparam logic [4:0]  CNT_PD_LO    = 5'h04; // after 4th edge
    localparam logic [4:0]  CNT_PD_HI    = 5'h0B; // 11th edge

    // ==========================================================
    // timing at 250 MHz
    // ==========================================================
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned T_CONV_PS     = 3300000; // 3.3 us max
    localparam int unsigned CONV_CYCLES   = T_CONV_PS / CLK_PERIOD_PS;
    localparam logic [11:0] CONV_CNT      = 12'(CONV_CYCLES);
    localparam logic [11:0] SYNC_LAT      = 12'h003; // pin edge to timer load
    localparam int unsigned T_QUIET_PS    = 100000; // 0.1 us
    localparam int unsigned QUIET_CYCLES  =
        (T_QUIET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  SCLK_HALF     = 8'h10; // host divider half
    localparam logic [11:0] RESET_RESULT  = 12'h000;

    typedef enum logic {
        SADC_MODE_INT,
        SADC_MODE_EXT
    } sadc_mode_t;

endpackage

/* File: shared/sadc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sadc_if;
    logic sclk;               // serial clock, host driven
    logic conversion_start_n; // start strobe / chip select, host driven
    logic sdo;                // serial_result_out data
    logic sdo_oe;             // serial_result_out enable

    modport device (
        input  sclk,
        input  conversion_start_n,
        output sdo,
        output sdo_oe
    );
    modport host (
        output sclk,
        output conversion_start_n,
        input  sdo,
        input  sdo_oe
    );
endinterface
`default_nettype wire

/* File: core/sadc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sadc_sync #(
    parameter logic RESET_LVL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= RESET_LVL;
            q_o    <= RESET_LVL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: core/sadc_device.sv */
// Summary of operation
// - ext mode: hold at select fall, track at 14th
// - host allows acquisition time before next sample
// - int mode: start fall holds and converts
// - int conversion ends in 3.3 us, loads result
// - int conversion end returns to track
// - host supplies sixteen clocks per read
// - after sixteen clocks reset shifter, release output
// - extra clocks restart shifting, output stays driven in int mode; ext releases it at each 16th fall
// - start fall resets shifter if clock low
// - host read must not span start fall
// - host keeps clock low during conversion
// - bits change on falls, first on rise in int mode, on select fall in ext
// - four zeros then 12-bit result, msb first
// - lsb valid at 16th fall, then release
// - reads may be split, position kept
// - host returns clock low after read
// - host waits quiet time before next start
// - power-up in internal clock mode
// - edge count selects the output bit
// - ext: select fall converts, early rise aborts
// - clock edge with select low during int conversion enters ext
// - ext: rise between edges 4 and 11 powers down
// - wake needs select low past 11th edge
`timescale 1ns/100ps
`default_nettype none
module sadc_device
    import sadc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    sadc_if.device           link,
    input  wire logic [11:0] sample_i,
    output logic             hold_o,
    output logic             conv_done_o,
    output logic             ext_mode_o,
    output logic             power_down_o,
    output logic [11:0]      result_o
);
    import sadc_pkg::*;

    // ==========================================================
    // input sampling
    // ==========================================================
    logic sclk_s;
    logic cs_s;
    logic sclk_d_r;
    logic cs_d_r;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    sadc_sync u_sync_sclk (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (link.sclk),
        .q_o      (sclk_s)
    );
    sadc_sync #(.RESET_LVL(1'b1)) u_sync_cs (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (link.conversion_start_n),
        .q_o      (cs_s)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign cs_fall   = ~cs_s & cs_d_r;
    assign cs_rise   = cs_s & ~cs_d_r;

    // ==========================================================
    // mode, conversion timer, power state
    // ==========================================================
    sadc_mode_t  mode_r;
    logic [11:0] conv_cnt_r;
    logic        converting_r;
    logic        edges_in_cs_r;
    logic        waking_r;
    logic [4:0]  bit_cnt_r;
    logic [11:0] out_reg_r;
    logic        ext_frame;

    assign ext_frame = (mode_r == SADC_MODE_EXT) & ~cs_s;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_r <= SADC_MODE_INT;
        end else if (mode_r == SADC_MODE_INT) begin
            if (converting_r && !cs_s && (sclk_rise || sclk_fall)) begin
                mode_r <= SADC_MODE_EXT;
            end
        end else if (cs_rise && !edges_in_cs_r) begin
            mode_r <= SADC_MODE_INT;
        end
    end

    // clock edges seen while select is low, for the mode return
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edges_in_cs_r <= 1'b0;
        end else if (cs_fall) begin
            edges_in_cs_r <= 1'b0;
        end else if (!cs_s && (sclk_rise || sclk_fall)) begin
            edges_in_cs_r <= 1'b1;
        end
    end

    // internal oscillator stand-in: fixed cycle count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            converting_r <= 1'b0;
            conv_cnt_r   <= 12'h000;
            conv_done_o  <= 1'b0;
        end else begin
            conv_done_o <= 1'b0;
            if (mode_r == SADC_MODE_EXT) begin
                converting_r <= 1'b0; // glitch aborts int conversion
            end else if (cs_fall) begin
                converting_r <= 1'b1;
                conv_cnt_r   <= CONV_CNT - SYNC_LAT; // keeps pin-to-done in max
            end else if (converting_r) begin
                if (conv_cnt_r == 12'h001) begin
                    converting_r <= 1'b0;
                    conv_done_o  <= 1'b1;
                end else begin
                    conv_cnt_r <= conv_cnt_r - 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_down_o <= 1'b0;
            waking_r     <= 1'b0;
        end else if (ext_frame && cs_fall) begin
            waking_r <= power_down_o;
        end else if (mode_r == SADC_MODE_EXT && cs_rise) begin
            if (waking_r) begin
                power_down_o <= (bit_cnt_r < CNT_PD_HI);
            end else if (bit_cnt_r >= CNT_PD_LO && bit_cnt_r < CNT_PD_HI) begin
                power_down_o <= 1'b1;
            end
            waking_r <= 1'b0;
        end else if (waking_r && bit_cnt_r >= CNT_FULL) begin
            power_down_o <= 1'b0;
            waking_r     <= 1'b0;
        end
    end

    // ==========================================================
    // track/hold
    // ==========================================================
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_o <= 1'b0;
        end else if (mode_r == SADC_MODE_INT) begin
            if (cs_fall) begin
                hold_o <= 1'b1;
            end else if (converting_r && conv_cnt_r == 12'h001) begin
                hold_o <= 1'b0;
            end
        end else if (cs_fall) begin
            hold_o <= 1'b1;
        end else if (cs_rise) begin
            hold_o <= 1'b0;
        end else if (ext_frame && sclk_fall
                     && bit_cnt_r == CNT_TRACK - 5'h01) begin
            hold_o <= 1'b0;
        end
    end

    // ==========================================================
    // result register and serial shifter
    // ==========================================================
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_reg_r <= RESET_RESULT;
        end else if (mode_r == SADC_MODE_INT && converting_r
                     && conv_cnt_r == 12'h001) begin
            out_reg_r <= sample_i;
        end else if (ext_frame && cs_fall) begin
            out_reg_r <= sample_i; // ext result sampled at hold
        end
    end

    assign result_o = out_reg_r;

    // count of falling edges in the frame; a fall at 16 wraps to 1
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_r <= 5'h00;
        end else if (cs_fall && !sclk_s) begin
            bit_cnt_r <= 5'h00;
        end else if (mode_r == SADC_MODE_EXT && cs_s) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_fall) begin
            if (bit_cnt_r == CNT_FULL) begin
                bit_cnt_r <= 5'h01;
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // bit index into 16-bit frame; zeros first then msb..lsb
    logic [3:0] idx;
    logic       frame_bit;

    assign idx = bit_cnt_r[3:0];

    always_comb begin
        if (idx < 4'(LEAD_ZEROS)) begin
            frame_bit = 1'b0;
        end else begin
            frame_bit = out_reg_r[4'(FRAME_BITS - 1) - idx];
        end
    end

    logic sdo_r;
    logic oe_r;
    logic wrapped_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wrapped_r <= 1'b0;
        end else if (cs_fall) begin
            wrapped_r <= 1'b0;
        end else if (sclk_fall && bit_cnt_r == CNT_FULL) begin
            wrapped_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_r  <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            sdo_r <= frame_bit;
            if (mode_r == SADC_MODE_EXT) begin
                oe_r <= ~cs_s && (bit_cnt_r < CNT_FULL) && ~cs_fall;
                if (cs_fall) begin
                    oe_r <= 1'b1; // first zero on select fall
                end
            end else if (cs_fall) begin
                oe_r <= 1'b0;
            end else if (sclk_rise && (bit_cnt_r == 5'h00
                                       || bit_cnt_r == CNT_FULL)) begin
                oe_r <= 1'b1;
            end else if (sclk_fall && bit_cnt_r == CNT_LAST) begin
                oe_r <= wrapped_r;
            end else if (sclk_fall && bit_cnt_r == CNT_FULL) begin
                oe_r <= 1'b1;
            end
        end
    end

    assign link.sdo    = sdo_r;
    assign link.sdo_oe = oe_r;
    assign ext_mode_o  = (mode_r == SADC_MODE_EXT);

endmodule
`default_nettype wire

/* File: core/sadc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sadc_host
    import sadc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    sadc_if.host             link,
    input  wire logic        start_i,
    input  wire logic        read_i,
    output logic             busy_o,
    output logic             data_valid_o,
    output logic [15:0]      data_o
);
    import sadc_pkg::*;

    // ==========================================================
    // host sequencer: strobe, wait, 16-clock read
    // ==========================================================
    typedef enum logic [2:0] {
        SADC_H_IDLE,
        SADC_H_STROBE,
        SADC_H_WAIT,
        SADC_H_HIGH,
        SADC_H_LOW,
        SADC_H_QUIET
    } sadc_hstate_t;

    sadc_hstate_t st_r;
    logic [11:0]  wait_r;
    logic [7:0]   div_r;
    logic [4:0]   n_r;
    logic [15:0]  sh_r;
    logic         sclk_r;
    logic         cs_r;
    logic         sdo_s;
    logic         dummy_oe;

    sadc_sync u_sync_sdo (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (link.sdo),
        .q_o      (sdo_s)
    );
    assign dummy_oe = link.sdo_oe;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r         <= SADC_H_IDLE;
            wait_r       <= 12'h000;
            div_r        <= 8'h00;
            n_r          <= 5'h00;
            sh_r         <= 16'h0000;
            sclk_r       <= 1'b0;
            cs_r         <= 1'b1;
            busy_o       <= 1'b0;
            data_valid_o <= 1'b0;
            data_o       <= 16'h0000;
        end else begin
            data_valid_o <= 1'b0;
            case (st_r)
                SADC_H_IDLE: begin
                    sclk_r <= 1'b0;
                    if (start_i) begin
                        cs_r   <= 1'b0;
                        busy_o <= 1'b1;
                        wait_r <= SCLK_HALF;
                        st_r   <= SADC_H_STROBE;
                    end else if (read_i) begin
                        busy_o <= 1'b1;
                        n_r    <= 5'h00;
                        div_r  <= SCLK_HALF;
                        st_r   <= SADC_H_HIGH;
                    end
                end
                SADC_H_STROBE: begin
                    if (wait_r == 12'h000) begin
                        cs_r   <= 1'b1;
                        wait_r <= CONV_CNT + 12'h010;
                        st_r   <= SADC_H_WAIT;
                    end else begin
                        wait_r <= wait_r - 12'h001;
                    end
                end
                SADC_H_WAIT: begin
                    if (wait_r == 12'h000) begin
                        n_r   <= 5'h00;
                        div_r <= SCLK_HALF;
                        st_r  <= SADC_H_HIGH;
                    end else begin
                        wait_r <= wait_r - 12'h001;
                    end
                end
                SADC_H_HIGH: begin
                    if (div_r == 8'h00) begin
                        sclk_r <= 1'b1;
                        div_r  <= SCLK_HALF;
                        st_r   <= SADC_H_LOW;
                    end else begin
                        div_r <= div_r - 8'h01;
                    end
                end
                SADC_H_LOW: begin
                    if (div_r == 8'h00) begin
                        sclk_r <= 1'b0;
                        sh_r   <= {sh_r[14:0], sdo_s}; // read at fall
                        n_r    <= n_r + 5'h01;
                        div_r  <= SCLK_HALF;
                        if (n_r == 5'(FRAME_BITS - 1)) begin
                            st_r   <= SADC_H_QUIET;
                            wait_r <= 12'(QUIET_CYCLES);
                        end else begin
                            st_r <= SADC_H_HIGH;
                        end
                    end else begin
                        div_r <= div_r - 8'h01;
                    end
                end
                SADC_H_QUIET: begin
                    if (wait_r == 12'h000) begin
                        data_o       <= sh_r;
                        data_valid_o <= 1'b1;
                        busy_o       <= 1'b0;
                        st_r         <= SADC_H_IDLE;
                    end else begin
                        wait_r <= wait_r - 12'h001;
                    end
                end
                default: begin
                    st_r <= SADC_H_IDLE;
                end
            endcase
        end
    end

    assign link.sclk               = sclk_r;
    assign link.conversion_start_n = cs_r;

endmodule
`default_nettype wire

/* File: dv/sadc_link_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sadc_link_sva
    import sadc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic sclk,
    input  wire logic conversion_start_n,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    // ==========================================================
    // helper state: serial position and idle times on the wire
    // ==========================================================
    logic        sclk_r;
    logic        strobe_r;
    logic [3:0]  fall_cnt_r;
    logic [11:0] conv_left_r;
    logic [7:0]  idle_cnt_r;
    logic [2:0]  since_fall_r;
    logic        done_r;
    logic        wrap_r;
    logic        sclk_fall;
    logic        strobe_fall;

    assign sclk_fall   = sclk_r & ~sclk;
    assign strobe_fall = strobe_r & ~conversion_start_n;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_r   <= 1'b0;
            strobe_r <= 1'b1;
        end else begin
            sclk_r   <= sclk;
            strobe_r <= conversion_start_n;
        end
    end

    // position wraps at sixteen like the device shifter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fall_cnt_r <= 4'h0;
        end else if (strobe_fall && !sclk) begin
            fall_cnt_r <= 4'h0;
        end else if (sclk_fall) begin
            fall_cnt_r <= fall_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_left_r <= 12'h000;
        end else if (strobe_fall) begin
            conv_left_r <= CONV_CNT;
        end else if (conv_left_r != 12'h000) begin
            conv_left_r <= conv_left_r - 12'h001;
        end
    end

    // saturating, so the first strobe after reset counts as quiet
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idle_cnt_r   <= 8'hFF;
            since_fall_r <= 3'h7;
        end else if (sclk_fall) begin
            idle_cnt_r   <= 8'h00;
            since_fall_r <= 3'h0;
        end else begin
            if (idle_cnt_r != 8'hFF) begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
            if (since_fall_r != 3'h7) begin
                since_fall_r <= since_fall_r + 3'h1;
            end
        end
    end

    // a fall after a finished frame with no strobe restarts the shifter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_r <= 1'b0;
            wrap_r <= 1'b0;
        end else if (strobe_fall) begin
            done_r <= 1'b0;
            wrap_r <= 1'b0;
        end else if (sclk_fall) begin
            if (fall_cnt_r == 4'hF) begin
                done_r <= 1'b1;
            end
            if (done_r) begin
                wrap_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    lead_zero_a: assert property (
        $fell(sclk) && fall_cnt_r < 4'h4 |-> sdo_oe && !sdo)
        else $error("leading zero missing at serial clock fall");
    lsb_release_a: assert property (
        $fell(sclk) && fall_cnt_r == 4'hF && !wrap_r |-> sdo_oe ##[1:8] !sdo_oe)
        else $error("last bit not held or output not released");
    wrap_driven_a: assert property (
        $fell(sclk) && fall_cnt_r == 4'hF && wrap_r |-> ##8 sdo_oe)
        else $error("output released after a restarted frame");
    first_bit_a: assert property (
        $rose(sclk) && fall_cnt_r == 4'h0 |-> ##[1:6] sdo_oe)
        else $error("first bit not driven after first rise");
    drop_point_a: assert property (
        $fell(sdo_oe) |-> fall_cnt_r == 4'h0)
        else $error("output released before sixteen falls");
    bit_steady_a: assert property (
        sdo_oe && $past(sdo_oe) && $changed(sdo) |-> since_fall_r <= 3'h6)
        else $error("data changed away from a serial clock fall");
    conv_quiet_a: assert property (
        $rose(sclk) |-> conv_left_r == 12'h000)
        else $error("serial clock rose during conversion");
    start_clean_a: assert property (
        $fell(conversion_start_n) |-> !sclk && fall_cnt_r == 4'h0)
        else $error("strobe fell inside a read");
    quiet_gap_a: assert property (
        $fell(conversion_start_n) |-> idle_cnt_r >= 8'(QUIET_CYCLES))
        else $error("strobe fell within quiet time");
endmodule
`default_nettype wire

/* File: dv/tb_serial_adc_conversion_readout.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_adc_conversion_readout;
    import sadc_pkg::*;
    logic        clk_i;
    logic        arst_n_i;
    logic        start_i;
    logic        read_i;
    logic        busy_o;
    logic        data_valid_o;
    logic [15:0] data_o;
    logic [11:0] sample_i;
    logic        hold_o;
    logic        conv_done_o;
    logic        ext_mode_o;
    logic        power_down_o;
    logic [11:0] result_o;
    logic [11:0] sample_b;
    logic        hold_b;
    logic        ext_b;
    logic        pd_b;
    logic        sdo_b;
    logic [15:0] frame_b;
    int          errors;
    int          tests_run;
    logic [11:0] samples [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF,
                                 12'hA5C};

    sadc_if link();
    sadc_if link_b();
    // no pull on the data wire: a released line reads as z
    assign sdo_b = link_b.sdo_oe ? link_b.sdo : 1'bz;

    sadc_host u_sadc_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link),
        .start_i(start_i), .read_i(read_i), .busy_o(busy_o),
        .data_valid_o(data_valid_o), .data_o(data_o));
    sadc_device u_sadc_device (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .link(link), .sample_i(sample_i), .hold_o(hold_o),
        .conv_done_o(conv_done_o), .ext_mode_o(ext_mode_o),
        .power_down_o(power_down_o), .result_o(result_o));
    sadc_device u_sadc_device_b (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .link(link_b), .sample_i(sample_b), .hold_o(hold_b),
        .conv_done_o(), .ext_mode_o(ext_b), .power_down_o(pd_b),
        .result_o());
    sadc_link_sva u_sadc_link_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .sclk(link.sclk), .conversion_start_n(link.conversion_start_n),
        .sdo(link.sdo), .sdo_oe(link.sdo_oe));

    always #2 clk_i = ~clk_i;

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic host_op(input logic rd, input logic [11:0] s);
        int n;
        sample_i <= s;
        start_i  <= ~rd;
        read_i   <= rd;
        @(posedge clk_i);
        start_i <= 1'b0;
        read_i  <= 1'b0;
        if (!rd) begin
            repeat (30) @(posedge clk_i);
            check("hold in conversion", {15'h0, hold_o}, 16'h1);
            n = 0;
            while (conv_done_o !== 1'b1 && n < 1000) begin
                @(posedge clk_i);
                n++;
            end
            check("conversion time", {15'h0, n + 29 <= CONV_CYCLES},
                  16'h1);
            check("result register", {4'h0, result_o}, {4'h0, s});
            repeat (10) @(posedge clk_i);
            check("track after conversion", {15'h0, hold_o}, 16'h0);
        end
        n = 0;
        while (data_valid_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        check("host frame", data_o, {4'h0, s});
    endtask

    // bench-made link clock, 125 ns, bit taken just before each fall
    task automatic b_clk(input int n);
        for (int i = 0; i < n; i++) begin
            #62.5 link_b.sclk = 1'b1;
            #62.5 frame_b = {frame_b[14:0], sdo_b};
            link_b.sclk = 1'b0;
        end
    endtask

    task automatic b_strobe(input logic [11:0] s);
        @(posedge clk_i);
        sample_b <= s;
        #100 link_b.conversion_start_n = 1'b0;
        #68 link_b.conversion_start_n = 1'b1;
        #4000;
    endtask

    task automatic b_select(input logic lvl);
        link_b.conversion_start_n = lvl;
        #500;
    endtask

    // ==========================================================
    // sequence
    // ==========================================================
    initial begin
        clk_i = 1'b0;
        arst_n_i = 1'b0;
        start_i = 1'b0;
        read_i = 1'b0;
        sample_i = 12'h000;
        sample_b = 12'h000;
        link_b.sclk = 1'b0;
        link_b.conversion_start_n = 1'b1;
        errors = 0;
        tests_run = 0;
        frame_b = 16'h0000;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("reset state", {11'h0, hold_o, ext_mode_o, power_down_o,
              link.sdo_oe, busy_o}, 16'h0);
        check("reset result", {4'h0, result_o}, {4'h0, RESET_RESULT});
        $display("test reset done");
        foreach (samples[i]) begin
            host_op(1'b0, samples[i]);
        end
        host_op(1'b1, 12'hA5C);
        $display("test host conversions done");

        b_strobe(12'h9C3);
        b_clk(8);
        #700;
        b_clk(8);
        check("split frame", frame_b, 16'h09C3);
        #300;
        check("released", {15'h0, sdo_b === 1'bz}, 16'h1);
        b_clk(3);
        #600;
        check("wrap driven", {15'h0, link_b.sdo_oe}, 16'h1);
        check("wrap restart", {13'h0, frame_b[2:0]}, 16'h0);
        b_strobe(12'h35A);
        b_clk(16);
        check("frame after strobe", frame_b, 16'h035A);
        $display("test internal mode link done");

        b_select(1'b0);
        b_clk(1);
        #300;
        check("enter ext mode", {15'h0, ext_b}, 16'h1);
        b_select(1'b1);
        @(posedge clk_i);
        sample_b <= 12'h6E1;
        b_select(1'b0);
        check("ext hold", {15'h0, hold_b}, 16'h1);
        b_clk(13);
        #300;
        check("hold at 13", {15'h0, hold_b}, 16'h1);
        b_clk(1);
        #300;
        check("track at 14", {15'h0, hold_b}, 16'h0);
        b_clk(2);
        check("ext frame", frame_b, 16'h06E1);
        #300;
        check("ext released", {15'h0, link_b.sdo_oe}, 16'h0);
        b_select(1'b1);
        b_select(1'b0);
        b_clk(6);
        b_select(1'b1);
        check("power down", {14'h0, pd_b, link_b.sdo_oe}, 16'h2);
        b_select(1'b0);
        b_clk(8);
        b_select(1'b1);
        check("early rise", {15'h0, pd_b}, 16'h1);
        b_select(1'b0);
        b_clk(16);
        b_select(1'b1);
        check("woken", {15'h0, pd_b}, 16'h0);
        b_select(1'b0);
        b_select(1'b1);
        check("back to int mode", {15'h0, ext_b}, 16'h0);
        $display("test external mode link done");
        final_report();
    end

    // whole run needs about 60 us; allow five times that
    initial begin
        #300000;
        errors++;
        $display("watchdog expired");
        final_report();
    end
endmodule
`default_nettype wire
